// File: hdl/stc_tick_counter.sv
// subsecond tick counter with Avalon-MM registers and tick interrupt flags
//
// Behaviour
// - one tick counter, fifteen bits wide.
// - counter normally advances from the slow crystal clock, not the processor clock.
// - four tick periods: 1, 0.5, 0.25 and 0.125 seconds.
// - counting goes on through stop, halt and hold standby.
// - a tick request can wake the core from stop and halt.
// - writing one to bit 0 clears the counter; the bit then self-clears.
// - control bit 1 gates tick requests on or off.
// - control bits 2 and 3 choose counter bit 11 to 14 as tap.
// - upper four control bits ignore writes and read as one.
// - counter adds one at each falling edge of the slow clock.
// - every system reset clears the counter to zero.
// - peripheral control bit 4 takes the slow clock from the input pin.
// - each tick event sets the tick request flag.
// - an enable flag permits or blocks servicing of the tick request.
// - two priority flags give the tick request one of four levels.
//
// The implementer's own choices: the register addresses and the Avalon-MM register port.
`timescale 1ns/10ps
`default_nettype none

module stc_tick_counter
    import stc_pkg::*;
#(
    parameter int CNT_WIDTH = CNT_WIDTH_DEF,
    parameter int SYNC_STAGES = SYNC_STAGES_DEF
) (
    input wire logic MCLK_IN,
    input wire logic RESETN_IN,
    input wire logic SYS_RESET_IN,
    input wire logic SLOW_CRYSTAL_CLOCK_IN,
    input wire logic SLOW_CRYSTAL_INPUT_PIN_IN,
    input wire logic [ADDR_W-1:0] AVS_ADDRESS_IN,
    input wire logic AVS_READ_IN,
    input wire logic AVS_WRITE_IN,
    input wire logic [DATA_W-1:0] AVS_WRITEDATA_IN,
    input wire logic [3:0] AVS_BYTEENABLE_IN,
    output logic [DATA_W-1:0] AVS_READDATA_OUT,
    output logic AVS_WAITREQUEST_OUT,
    output logic TICK_IRQ_OUT,
    output logic [1:0] TICK_PRIORITY_OUT,
    output logic WAKE_OUT
);

    // ========================================
    // elaboration checks
    if (CNT_WIDTH < TAP_LOW + TAP_COUNT || CNT_WIDTH >= DATA_W) begin : g_bad_width
        $error("counter width cannot hold the tap bits");
    end
    if (SYNC_STAGES < SYNC_STAGES_DEF) begin : g_bad_sync
        $error("sampler needs at least three stages");
    end
    if (MCLK_HZ < SLOW_CLK_HZ * MIN_OVERSAMPLE) begin : g_bad_rate
        $error("core clock too slow to sample the slow clock");
    end

    // ========================================
    // declarations
    logic [SRC_COUNT-1:0] pin_raw;
    logic [SRC_COUNT-1:0] pin_fall;
    logic tick;
    logic [CNT_WIDTH-1:0] cnt_reg;
    logic [CNT_WIDTH-1:0] cnt_inc;
    logic [TAP_COUNT-1:0] tap;
    logic [TAP_COUNT-1:0] tap_inc;
    logic tap_sel_bit;
    logic tick_event;
    logic counter_clear_bit_reg;
    logic tick_irq_gate_reg;
    logic [1:0] period_select_reg;
    logic external_slow_clock_select_reg;
    logic tick_request_flag_reg;
    logic tick_enable_flag_reg;
    logic tick_priority_bit0_reg;
    logic tick_priority_bit1_reg;
    logic wait_reg;
    logic [DATA_W-1:0] rdata_reg;
    logic [DATA_W-1:0] rdata_next;
    logic irq_reg;
    logic wake_reg;
    logic [1:0] prio_reg;
    logic wr_fire;
    logic ctrl_wr;
    logic periph_wr;
    logic req_wr;
    logic en_wr;
    logic prio_wr;
    logic [7:0] ctrl_rd_val;

    // ========================================
    // slow clock sampling
    assign pin_raw = {SLOW_CRYSTAL_INPUT_PIN_IN, SLOW_CRYSTAL_CLOCK_IN};

    // each source: shift chain, level follows once the last two stages agree
    for (genvar gi = 0; gi < SRC_COUNT; gi++) begin : g_sync
        logic [SYNC_STAGES-1:0] sync_reg;
        logic level_reg;
        logic agree;

        always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
            if (!RESETN_IN) begin
                sync_reg <= '0;
            end else begin
                sync_reg <= {sync_reg[SYNC_STAGES-2:0], pin_raw[gi]};
            end
        end

        assign agree = sync_reg[SYNC_STAGES-1] == sync_reg[SYNC_STAGES-2];

        // filtered level of the pin
        always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
            if (!RESETN_IN) begin
                level_reg <= 1'b0;
            end else if (agree) begin
                level_reg <= sync_reg[SYNC_STAGES-1];
            end
        end

        // one-cycle pulse when the filtered level falls
        assign pin_fall[gi] = level_reg && agree && !sync_reg[SYNC_STAGES-1];
    end

    // source select: oscillator clock unless the input pin is chosen
    assign tick = external_slow_clock_select_reg ? pin_fall[1] : pin_fall[0];

    // ========================================
    // tick counter
    assign cnt_inc = cnt_reg + CNT_WIDTH'(1);

    // counts on every slow fall, standby has no say here
    always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            cnt_reg <= '0;
        end else if (SYS_RESET_IN) begin
            cnt_reg <= '0;
        end else if (counter_clear_bit_reg) begin
            cnt_reg <= '0;
        end else if (tick) begin
            cnt_reg <= cnt_inc;
        end
    end

    // ========================================
    // period tap and tick event
    assign tap = cnt_reg[TAP_LOW +: TAP_COUNT];
    assign tap_inc = cnt_inc[TAP_LOW +: TAP_COUNT];
    assign tap_sel_bit = tap[period_select_reg];

    // event when the chosen tap falls through counting
    assign tick_event = tick && !counter_clear_bit_reg && !SYS_RESET_IN
                        && tap_sel_bit && !tap_inc[period_select_reg]
                        && tick_irq_gate_reg;

    // ========================================
    // bus decode
    assign wr_fire = AVS_WRITE_IN && !wait_reg && AVS_BYTEENABLE_IN[0];
    assign ctrl_wr = wr_fire && AVS_ADDRESS_IN == CONTROL_OFS;
    assign periph_wr = wr_fire && AVS_ADDRESS_IN == PERIPH_OFS;
    assign req_wr = wr_fire && AVS_ADDRESS_IN == IRQ_REQ_OFS;
    assign en_wr = wr_fire && AVS_ADDRESS_IN == IRQ_EN_OFS;
    assign prio_wr = wr_fire && AVS_ADDRESS_IN == IRQ_PRIO_OFS;

    // ========================================
    // control register
    assign ctrl_rd_val = {CONTROL_FILL, period_select_reg,
                          tick_irq_gate_reg, counter_clear_bit_reg};

    // clear bit drops by itself at the edge that clears the counter
    always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            counter_clear_bit_reg <= CONTROL_RESET[CLEAR_BIT];
        end else if (SYS_RESET_IN) begin
            counter_clear_bit_reg <= CONTROL_RESET[CLEAR_BIT];
        end else if (ctrl_wr) begin
            counter_clear_bit_reg <= AVS_WRITEDATA_IN[CLEAR_BIT];
        end else if (counter_clear_bit_reg) begin
            counter_clear_bit_reg <= 1'b0;
        end
    end

    // gate and period select
    always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            tick_irq_gate_reg <= CONTROL_RESET[GATE_BIT];
            period_select_reg <= SEL_RESET;
        end else if (SYS_RESET_IN) begin
            tick_irq_gate_reg <= CONTROL_RESET[GATE_BIT];
            period_select_reg <= SEL_RESET;
        end else if (ctrl_wr) begin
            tick_irq_gate_reg <= AVS_WRITEDATA_IN[GATE_BIT];
            period_select_reg <= AVS_WRITEDATA_IN[SEL_HI_BIT:SEL_LO_BIT];
        end
    end

    // peripheral control: slow clock source
    always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            external_slow_clock_select_reg <= 1'b0;
        end else if (SYS_RESET_IN) begin
            external_slow_clock_select_reg <= 1'b0;
        end else if (periph_wr) begin
            external_slow_clock_select_reg <= AVS_WRITEDATA_IN[EXT_SEL_BIT];
        end
    end

    // ========================================
    // interrupt flags
    // request flag: event beats a write-one clear in the same cycle
    always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            tick_request_flag_reg <= 1'b0;
        end else if (SYS_RESET_IN) begin
            tick_request_flag_reg <= 1'b0;
        end else if (tick_event) begin
            tick_request_flag_reg <= 1'b1;
        end else if (req_wr && AVS_WRITEDATA_IN[FLAG_BIT]) begin
            tick_request_flag_reg <= 1'b0;
        end
    end

    // enable flag
    always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            tick_enable_flag_reg <= 1'b0;
        end else if (SYS_RESET_IN) begin
            tick_enable_flag_reg <= 1'b0;
        end else if (en_wr) begin
            tick_enable_flag_reg <= AVS_WRITEDATA_IN[FLAG_BIT];
        end
    end

    // priority flags
    always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            tick_priority_bit0_reg <= PRIO_RESET[PRIO0_BIT];
            tick_priority_bit1_reg <= PRIO_RESET[PRIO1_BIT];
        end else if (SYS_RESET_IN) begin
            tick_priority_bit0_reg <= PRIO_RESET[PRIO0_BIT];
            tick_priority_bit1_reg <= PRIO_RESET[PRIO1_BIT];
        end else if (prio_wr) begin
            tick_priority_bit0_reg <= AVS_WRITEDATA_IN[PRIO0_BIT];
            tick_priority_bit1_reg <= AVS_WRITEDATA_IN[PRIO1_BIT];
        end
    end

    // outputs toward the interrupt controller and power control
    always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            irq_reg <= 1'b0;
            wake_reg <= 1'b0;
            prio_reg <= PRIO_RESET;
        end else begin
            irq_reg <= tick_request_flag_reg && tick_enable_flag_reg;
            wake_reg <= tick_event && tick_enable_flag_reg;
            prio_reg <= {tick_priority_bit1_reg, tick_priority_bit0_reg};
        end
    end

    // ========================================
    // bus slave: one wait cycle on every access
    always_comb begin
        rdata_next = READ_ZERO;
        unique case (AVS_ADDRESS_IN)
            CONTROL_OFS: rdata_next[7:0] = ctrl_rd_val;
            PERIPH_OFS: rdata_next[EXT_SEL_BIT] = external_slow_clock_select_reg;
            IRQ_REQ_OFS: rdata_next[FLAG_BIT] = tick_request_flag_reg;
            IRQ_EN_OFS: rdata_next[FLAG_BIT] = tick_enable_flag_reg;
            IRQ_PRIO_OFS: rdata_next[1:0] = {tick_priority_bit1_reg, tick_priority_bit0_reg};
            COUNT_OFS: rdata_next[CNT_WIDTH-1:0] = cnt_reg;
            default: rdata_next = READ_ZERO; // unmapped reads zero
        endcase
    end

    // waitrequest drops for exactly one cycle per request
    always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            wait_reg <= 1'b1;
        end else begin
            wait_reg <= !((AVS_READ_IN || AVS_WRITE_IN) && wait_reg);
        end
    end

    // read data captured in the waiting cycle
    always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            rdata_reg <= READ_ZERO;
        end else if (AVS_READ_IN && wait_reg) begin
            rdata_reg <= rdata_next;
        end
    end

    assign AVS_READDATA_OUT = rdata_reg;
    assign AVS_WAITREQUEST_OUT = wait_reg;
    assign TICK_IRQ_OUT = irq_reg;
    assign TICK_PRIORITY_OUT = prio_reg;
    assign WAKE_OUT = wake_reg;

    // ========================================
    // assertions
    default clocking cb @(posedge MCLK_IN);
    endclocking
    default disable iff (!RESETN_IN);

    property p_count_step;
        tick && !counter_clear_bit_reg && !SYS_RESET_IN |=> cnt_reg == $past(cnt_reg) + CNT_WIDTH'(1);
    endproperty
    a_count_step: assert property (p_count_step) else $error("counter did not step by one");
    property p_count_hold;
        !tick && !counter_clear_bit_reg && !SYS_RESET_IN |=> $stable(cnt_reg);
    endproperty
    a_count_hold: assert property (p_count_hold) else $error("counter moved without a tick");
    property p_clear;
        ctrl_wr && AVS_WRITEDATA_IN[CLEAR_BIT] && !SYS_RESET_IN
            |=> counter_clear_bit_reg ##1 (cnt_reg == '0 && !counter_clear_bit_reg);
    endproperty
    a_clear: assert property (p_clear) else $error("clear bit did not clear and drop");
    property p_upper_ones;
        AVS_READ_IN && wait_reg && AVS_ADDRESS_IN == CONTROL_OFS
            |=> !AVS_WAITREQUEST_OUT && AVS_READDATA_OUT[7:4] == CONTROL_FILL;
    endproperty
    a_upper_ones: assert property (p_upper_ones) else $error("control upper bits not one");
    property p_sys_reset;
        SYS_RESET_IN |=> cnt_reg == '0 && ctrl_rd_val == CONTROL_RESET;
    endproperty
    a_sys_reset: assert property (p_sys_reset) else $error("system reset state wrong");
    property p_tap;
        tick_event && !ctrl_wr |=> !tap_sel_bit && cnt_reg[TAP_LOW-1:0] == '0;
    endproperty
    a_tap: assert property (p_tap) else $error("event not at fall of chosen tap");
    property p_gate;
        !tick_irq_gate_reg |=> !$rose(tick_request_flag_reg);
    endproperty
    a_gate: assert property (p_gate) else $error("request set while gated off");
    property p_flag_set;
        tick_event |=> tick_request_flag_reg;
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("event lost");
    property p_irq;
        tick_request_flag_reg && tick_enable_flag_reg |=> TICK_IRQ_OUT;
    endproperty
    a_irq: assert property (p_irq) else $error("enabled request not raised");
    property p_prio;
        prio_wr && !SYS_RESET_IN |=> ##1 TICK_PRIORITY_OUT == $past(AVS_WRITEDATA_IN[1:0], 2);
    endproperty
    a_prio: assert property (p_prio) else $error("priority output wrong");
    property p_once;
        tick_event |=> !tick_event;
    endproperty
    a_once: assert property (p_once) else $error("event repeated");
    property p_wake;
        tick_event && tick_enable_flag_reg |=> WAKE_OUT;
    endproperty
    a_wake: assert property (p_wake) else $error("no wake pulse");
    property p_ext;
        external_slow_clock_select_reg && pin_fall[0] && !pin_fall[1]
            && !counter_clear_bit_reg && !SYS_RESET_IN |=> $stable(cnt_reg);
    endproperty
    a_ext: assert property (p_ext) else $error("oscillator counted in pin mode");
    c_event: cover property (tick_event);
    c_clear: cover property (counter_clear_bit_reg ##1 cnt_reg == '0);
    c_ext_tick: cover property (external_slow_clock_select_reg && tick);
    c_wake: cover property (WAKE_OUT);

endmodule : stc_tick_counter

`default_nettype wire

// File: hdl/stc_pkg.sv
// constants, register map and field layout of the subsecond tick counter
package stc_pkg;

    // ========================================
    // sizes
    localparam int CNT_WIDTH_DEF = 15;
    localparam int SYNC_STAGES_DEF = 3;
    localparam int TAP_LOW = 11;
    localparam int TAP_COUNT = 4;
    localparam int DATA_W = 32;
    localparam int ADDR_W = 5;
    localparam int SRC_COUNT = 2;

    // ========================================
    // clock rates
    localparam int SLOW_CLK_HZ = 32_768;
    localparam int MCLK_HZ = 100_000_000;
    localparam int MIN_OVERSAMPLE = 8;

    // ========================================
    // register byte offsets
    localparam logic [ADDR_W-1:0] CONTROL_OFS = 5'h00;
    localparam logic [ADDR_W-1:0] PERIPH_OFS = 5'h04;
    localparam logic [ADDR_W-1:0] IRQ_REQ_OFS = 5'h08;
    localparam logic [ADDR_W-1:0] IRQ_EN_OFS = 5'h0c;
    localparam logic [ADDR_W-1:0] IRQ_PRIO_OFS = 5'h10;
    localparam logic [ADDR_W-1:0] COUNT_OFS = 5'h14;

    // ========================================
    // field positions
    localparam int CLEAR_BIT = 0;
    localparam int GATE_BIT = 1;
    localparam int SEL_LO_BIT = 2;
    localparam int SEL_HI_BIT = 3;
    localparam int EXT_SEL_BIT = 4;
    localparam int FLAG_BIT = 0;
    localparam int PRIO0_BIT = 0;
    localparam int PRIO1_BIT = 1;

    // ========================================
    // reset and fill values
    localparam logic [7:0] CONTROL_RESET = 8'hf0;
    localparam logic [3:0] CONTROL_FILL = 4'hf;
    localparam logic [1:0] SEL_RESET = 2'h0;
    localparam logic [1:0] PRIO_RESET = 2'h0;
    localparam logic [DATA_W-1:0] READ_ZERO = 32'h0000_0000;

endpackage : stc_pkg

// File: test/stc_slow_src.sv
// slow clock source model: crystal oscillator and external clock on the input pin
`timescale 1ns/10ps
`default_nettype none

module stc_slow_src #(
    parameter int HALF = 4
) (
    input wire logic MCLK_IN,
    output logic XTAL_OUT,
    output logic PIN_OUT
);
    // ========================================
    // both lines stand still high outside bursts
    initial begin
        XTAL_OUT = 1'b1;
        PIN_OUT = 1'b1;
    end

    // ========================================
    // burst of k falling edges on one line, the other line held still
    task automatic falls(input logic use_pin, input int k);
        for (int i = 0; i < k; i++) begin
            @(posedge MCLK_IN);
            if (use_pin) begin
                PIN_OUT <= 1'b0;
            end else begin
                XTAL_OUT <= 1'b0;
            end
            repeat (HALF) @(posedge MCLK_IN);
            PIN_OUT <= 1'b1;
            XTAL_OUT <= 1'b1;
            repeat (HALF - 1) @(posedge MCLK_IN);
        end
    endtask : falls
endmodule : stc_slow_src
`default_nettype wire

// File: test/tb.sv
// self-checking testbench of the subsecond tick counter
`timescale 1ns/10ps
`default_nettype none

module tb;
    import stc_pkg::*;

    logic mclk;
    logic rstn;
    logic sysr;
    logic xtal;
    logic pin;
    logic [ADDR_W-1:0] addr;
    logic rd;
    logic wr;
    logic [DATA_W-1:0] wdata;
    logic [3:0] be;
    logic [DATA_W-1:0] rdata;
    logic waitreq;
    logic irq;
    logic [1:0] prio;
    logic wake;
    logic [DATA_W-1:0] base;
    int n_fail;
    int checked;
    int wakes = 0;

    // ========================================
    // design and slow clock source
    stc_tick_counter dut_u (
        .MCLK_IN(mclk), .RESETN_IN(rstn), .SYS_RESET_IN(sysr),
        .SLOW_CRYSTAL_CLOCK_IN(xtal), .SLOW_CRYSTAL_INPUT_PIN_IN(pin),
        .AVS_ADDRESS_IN(addr), .AVS_READ_IN(rd), .AVS_WRITE_IN(wr),
        .AVS_WRITEDATA_IN(wdata), .AVS_BYTEENABLE_IN(be),
        .AVS_READDATA_OUT(rdata), .AVS_WAITREQUEST_OUT(waitreq),
        .TICK_IRQ_OUT(irq), .TICK_PRIORITY_OUT(prio), .WAKE_OUT(wake)
    );
    // three core cycles per half period keeps the long periods inside the run budget
    stc_slow_src #(.HALF(3)) src_u (.MCLK_IN(mclk), .XTAL_OUT(xtal), .PIN_OUT(pin));

    // ========================================
    // 100 MHz clock
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // counts wake pulses
    always @(posedge mclk) begin
        if (wake === 1'b1) wakes <= wakes + 1;
    end

    // ========================================
    // report and bus tasks
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : final_report

    task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // one access, held until waitrequest is sampled low
    task automatic avs(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                       input logic [3:0] b, output logic [DATA_W-1:0] q);
        int n;
        n = 0;
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        be <= b;
        wr <= w;
        rd <= ~w;
        do begin
            @(posedge mclk);
            n++;
        end while (waitreq !== 1'b0 && n < 20);
        q = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
        if (n >= 20) begin
            n_fail++;
            final_report();
        end
    endtask : avs

    task automatic wrr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        logic [DATA_W-1:0] q;
        avs(1'b1, a, d, 4'hf, q);
    endtask : wrr

    task automatic rdc(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
        logic [DATA_W-1:0] q;
        avs(1'b0, a, 32'h0000_0000, 4'hf, q);
        chk(q, exp);
    endtask : rdc

    task automatic idle(input int n);
        repeat (n) @(posedge mclk);
    endtask : idle

    // ========================================
    // hang guard
    initial begin
        #900000;
        n_fail++;
        final_report();
    end

    // ========================================
    // main sequence
    initial begin
        rstn = 1'b0;
        sysr = 1'b0;
        addr = '0;
        rd = 1'b0;
        wr = 1'b0;
        wdata = '0;
        be = 4'hf;
        n_fail = 0;
        checked = 0;
        repeat (12) @(posedge mclk);
        rstn <= 1'b1;
        idle(4);
        rdc(CONTROL_OFS, 32'h0000_00f0);
        rdc(COUNT_OFS, 32'h0000_0000);
        rdc(IRQ_REQ_OFS, 32'h0000_0000);
        // every period code with the gate on, upper bits written zero
        for (int s = 0; s < 4; s++) begin
            wrr(CONTROL_OFS, 32'(s << 2) | 32'h0000_0002);
            rdc(CONTROL_OFS, 32'(s << 2) | 32'h0000_00f2);
        end
        avs(1'b1, CONTROL_OFS, 32'h0000_0000, 4'h0, base);
        rdc(CONTROL_OFS, 32'h0000_00fe);
        wrr(5'h18, 32'hffff_ffff);
        rdc(5'h18, 32'h0000_0000);
        // counting from the crystal, no standby input can stop it
        avs(1'b0, COUNT_OFS, 32'h0000_0000, 4'hf, base);
        src_u.falls(1'b0, 37);
        idle(10);
        rdc(COUNT_OFS, base + 32'h0000_0025);
        wrr(CONTROL_OFS, 32'h0000_0001);
        rdc(COUNT_OFS, 32'h0000_0000);
        rdc(CONTROL_OFS, 32'h0000_00f0);
        // external clock on the input pin, crystal then ignored
        wrr(PERIPH_OFS, 32'h0000_0010);
        rdc(PERIPH_OFS, 32'h0000_0010);
        avs(1'b0, COUNT_OFS, 32'h0000_0000, 4'hf, base);
        src_u.falls(1'b1, 21);
        src_u.falls(1'b0, 5);
        idle(10);
        rdc(COUNT_OFS, base + 32'h0000_0015);
        wrr(PERIPH_OFS, 32'h0000_0000);
        // priority codes reach the output
        for (int p = 0; p < 4; p++) begin
            wrr(IRQ_PRIO_OFS, 32'(p));
            rdc(IRQ_PRIO_OFS, 32'(p));
            chk({30'h0000_0000, prio}, 32'(p));
        end
        // tick at counter bit 11, exactly at the 4096th fall
        wrr(IRQ_EN_OFS, 32'h0000_0001);
        wrr(CONTROL_OFS, 32'h0000_0003);
        src_u.falls(1'b0, 4095);
        idle(10);
        rdc(IRQ_REQ_OFS, 32'h0000_0000);
        chk(32'(wakes), 32'h0000_0000);
        src_u.falls(1'b0, 1);
        idle(10);
        rdc(IRQ_REQ_OFS, 32'h0000_0001);
        chk({31'h0000_0000, irq}, 32'h0000_0001);
        chk(32'(wakes), 32'h0000_0001);
        wrr(IRQ_EN_OFS, 32'h0000_0000);
        idle(3);
        chk({31'h0000_0000, irq}, 32'h0000_0000);
        rdc(IRQ_REQ_OFS, 32'h0000_0001);
        wrr(IRQ_REQ_OFS, 32'h0000_0001);
        rdc(IRQ_REQ_OFS, 32'h0000_0000);
        // gate off: a full period passes with no request
        wrr(IRQ_EN_OFS, 32'h0000_0001);
        wrr(CONTROL_OFS, 32'h0000_0001);
        src_u.falls(1'b0, 4096);
        idle(10);
        rdc(IRQ_REQ_OFS, 32'h0000_0000);
        chk(32'(wakes), 32'h0000_0001);
        rdc(COUNT_OFS, 32'h0000_1000);
        // period code 01: next request when counter bit 12 falls at 0x2000
        wrr(CONTROL_OFS, 32'h0000_0006);
        src_u.falls(1'b0, 4095);
        idle(10);
        rdc(IRQ_REQ_OFS, 32'h0000_0000);
        src_u.falls(1'b0, 1);
        idle(10);
        rdc(IRQ_REQ_OFS, 32'h0000_0001);
        chk(32'(wakes), 32'h0000_0002);
        // system reset source in mid-run
        wrr(CONTROL_OFS, 32'h0000_000e);
        @(posedge mclk);
        sysr <= 1'b1;
        @(posedge mclk);
        sysr <= 1'b0;
        rdc(CONTROL_OFS, 32'h0000_00f0);
        rdc(COUNT_OFS, 32'h0000_0000);
        rdc(IRQ_EN_OFS, 32'h0000_0000);
        final_report();
    end
endmodule : tb
`default_nettype wire
